// File: src/asw_pkg.sv
// Shared constants, types and register map of the scan and window control.
// Assumes a single 250 MHz system clock and an AXI4-Lite master upstream.
package asw_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] ASW_IDX_A_HIGH_UPPER = 10'h0f8;
  localparam logic [9:0] ASW_IDX_A_HIGH_LOWER = 10'h0f9;
  localparam logic [9:0] ASW_IDX_B_HIGH_UPPER = 10'h0fa;
  localparam logic [9:0] ASW_IDX_B_HIGH_LOWER = 10'h0fb;
  localparam logic [9:0] ASW_IDX_SCAN_SETUP   = 10'h0fc;
  localparam logic [9:0] ASW_IDX_RUN_SETUP    = 10'h0fd;
  localparam logic [9:0] ASW_IDX_LOW_LIMITS   = 10'h0f0;
  localparam logic [9:0] ASW_IDX_FLAGS        = 10'h0fe;
  localparam logic [9:0] ASW_IDX_STATUS       = 10'h0ff;

  // Reset values.
  localparam logic [7:0] ASW_RST_SCAN_SETUP = 8'h0f;
  localparam logic [7:0] ASW_RST_RUN_SETUP  = 8'ha0;
  localparam logic [9:0] ASW_RST_LIMIT      = 10'h000;

  // Field positions of the run setup register.
  localparam int ASW_RUN_DIV_MSB   = 7;
  localparam int ASW_RUN_DIV_LSB   = 5;
  localparam int ASW_RUN_PIN_EN    = 4;
  localparam int ASW_RUN_TIMER_EN  = 3;
  localparam int ASW_RUN_POWER     = 2;
  localparam int ASW_RUN_REPEAT    = 1;
  localparam int ASW_RUN_REQUEST   = 0;

  // Field positions of the flags register.
  localparam int ASW_FLG_SEQ_DONE  = 7;
  localparam int ASW_FLG_ALARM     = 6;
  localparam int ASW_FLG_B_OVER    = 5;
  localparam int ASW_FLG_A_OVER    = 4;
  localparam int ASW_FLG_B_UNDER   = 3;
  localparam int ASW_FLG_A_UNDER   = 2;

  // Conversion timing in ADC clock periods.
  localparam logic [4:0] ASW_SAMPLE_PERIODS = 5'h08;
  localparam logic [4:0] ASW_CONV_PERIODS   = 5'h1c;
  localparam logic [3:0] ASW_LAST_CHANNEL   = 4'hf;

  localparam logic [1:0] ASW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ASW_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    S_IDLE    = 2'b00,
    S_SAMPLE  = 2'b01,
    S_CONVERT = 2'b11
  } asw_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } asw_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } asw_axi_rsp_t;

  typedef struct packed {
    logic       analogEnable;
    logic       adcClk;
    logic [3:0] channel;
    logic       busy;
    logic       holdPhase;
  } asw_core_ctl_t;

endpackage : asw_pkg

// File: src/asw_ctrl.sv
// Scan sequencer, window limits, prescaler and trigger logic of the ADC.
// Assumes the conversion core presents the result on convResult when the
// last ADC clock period of a conversion ends, and synchronous inputs.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Each compared channel keeps a ten-bit upper limit split over two bytes.
// - Six low bits of each limit low byte always read zero.
// - Autoscan starts at the first channel, increments, ends after channel 15.
// - First channel field all ones converts only channel 15.
// - Pair select gives channel B; channel A is one lower, wrapping.
// - Any write with byte lane 0 to either control register restarts from the first channel.
// - ADC clock period is twice the divider code plus two clocks.
// - Pin trigger enable makes the next falling trigger pin edge start a sequence.
// - Timer trigger enable makes the timer event start a sequence.
// - Pin and timer triggers are ORed; software enables only one.
// - Triggers set run request; single mode clears it after each sequence.
// - Power bit zero idles converter logic; one enables it.
// - Single mode runs exactly one sequence per start.
// - Repeat mode runs sequences back to back after the first start.
// - Writing one to run request starts; writing zero stops.
// - Conversions of compared channels set over and under limit flags.
// - Threshold crossings set the alarm flag; software clears or sets it.
// - Sequence end sets the done flag; software clears or sets it.
module asw_ctrl (
  input  wire logic                  clk,             // System clock.
  input  wire logic                  rst_n,           // Sync reset.
  input  wire asw_pkg::asw_axi_req_t axiReq,          // Bus requests.
  output var  asw_pkg::asw_axi_rsp_t axiRsp,          // Bus answers.
  input  wire logic                  triggerInputPin, // Falling edge starts.
  input  wire logic                  timerEvent,      // One-cycle pulse.
  input  wire logic [9:0]            convResult,      // Core result.
  output var  asw_pkg::asw_core_ctl_t coreCtl         // Core control.
);
  import asw_pkg::*;

  logic       awHeld_ff, wHeld_ff, awReady_ff, wReady_ff, bValid_ff;
  logic       arReady_ff, rValid_ff;
  logic [1:0] bResp_ff, rResp_ff;
  logic [31:0] rData_ff, wData_ff;
  logic [9:0] wrIdx_ff;
  logic [3:0] wStrb_ff;

  logic [9:0] upperA_ff, upperB_ff, lowerA_ff, lowerB_ff;
  logic [3:0] firstChan_ff, pairSel_ff;
  logic [2:0] div_ff;
  logic       pinEn_ff, timerEn_ff, power_ff, repeat_ff, runReq_ff;
  logic       seqDone_ff, alarm_ff, aOver_ff, bOver_ff, aUnder_ff, bUnder_ff;
  logic       pinPrev_ff, adcClk_ff;
  logic [2:0] divCnt_ff;
  logic [4:0] perCnt_ff;
  logic [3:0] chan_ff;
  asw_state_t state_ff;

  logic awTake, wTake, arTake, wrFire, wrHit, wrMapped;
  logic nxt_awHeld, nxt_wHeld, nxt_rValid;
  logic wrScan, wrRun, wrFlags, ctlWrite, trigger;
  logic periodEnd, convEnd, seqEnd, startSeq, abort;
  logic [3:0] chanA, chanB;
  logic [7:0] rdByte;
  logic [31:0] rdWord;
  logic rdMapped;
  logic [9:0] rdIdx;

  // Bus handshakes: address and data are taken independently and the write
  // is performed once both are held and no response is outstanding.
  assign awTake     = axiReq.awvalid & awReady_ff;
  assign wTake      = axiReq.wvalid & wReady_ff;
  assign wrFire     = awHeld_ff & wHeld_ff & ~bValid_ff;
  assign nxt_awHeld = awTake | (awHeld_ff & ~wrFire);
  assign nxt_wHeld  = wTake | (wHeld_ff & ~wrFire);
  assign arTake     = axiReq.arvalid & arReady_ff;
  assign nxt_rValid = arTake | (rValid_ff & ~axiReq.rready);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_ff  <= 1'b0;
      wHeld_ff   <= 1'b0;
      awReady_ff <= 1'b0;
      wReady_ff  <= 1'b0;
      bValid_ff  <= 1'b0;
      bResp_ff   <= ASW_RESP_OKAY;
      wrIdx_ff   <= 10'h000;
      wData_ff   <= 32'h0000_0000;
      wStrb_ff   <= 4'h0;
    end else begin
      awHeld_ff  <= nxt_awHeld;
      wHeld_ff   <= nxt_wHeld;
      awReady_ff <= ~nxt_awHeld;
      wReady_ff  <= ~nxt_wHeld;
      if (awTake) begin
        wrIdx_ff <= axiReq.awaddr[11:2];
      end
      if (wTake) begin
        wData_ff <= axiReq.wdata;
        wStrb_ff <= axiReq.wstrb;
      end
      if (wrFire) begin
        bValid_ff <= 1'b1;
        bResp_ff  <= wrMapped ? ASW_RESP_OKAY : ASW_RESP_SLVERR;
      end else if (axiReq.bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    case (wrIdx_ff)
      ASW_IDX_A_HIGH_UPPER, ASW_IDX_A_HIGH_LOWER, ASW_IDX_B_HIGH_UPPER,
      ASW_IDX_B_HIGH_LOWER, ASW_IDX_SCAN_SETUP, ASW_IDX_RUN_SETUP,
      ASW_IDX_LOW_LIMITS, ASW_IDX_FLAGS, ASW_IDX_STATUS: wrMapped = 1'b1;
      default: wrMapped = 1'b0;
    endcase
  end

  // Byte lane 0 carries every 8-bit register; other lanes only the lower
  // limits, so a write without lane 0 leaves the byte registers alone.
  assign wrHit    = wrFire & wStrb_ff[0];
  assign wrScan   = wrHit & (wrIdx_ff == ASW_IDX_SCAN_SETUP);
  assign wrRun    = wrHit & (wrIdx_ff == ASW_IDX_RUN_SETUP);
  assign wrFlags  = wrHit & (wrIdx_ff == ASW_IDX_FLAGS);
  assign ctlWrite = wrScan | wrRun;

  // Window limits.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upperA_ff <= ASW_RST_LIMIT;
      upperB_ff <= ASW_RST_LIMIT;
      lowerA_ff <= ASW_RST_LIMIT;
      lowerB_ff <= ASW_RST_LIMIT;
    end else if (wrHit) begin
      case (wrIdx_ff)
        ASW_IDX_A_HIGH_UPPER: upperA_ff[9:2] <= wData_ff[7:0];
        ASW_IDX_A_HIGH_LOWER: upperA_ff[1:0] <= wData_ff[7:6];
        ASW_IDX_B_HIGH_UPPER: upperB_ff[9:2] <= wData_ff[7:0];
        ASW_IDX_B_HIGH_LOWER: upperB_ff[1:0] <= wData_ff[7:6];
        ASW_IDX_LOW_LIMITS: begin
          lowerA_ff <= wData_ff[9:0];
          if (wStrb_ff[2]) begin
            lowerB_ff <= wData_ff[25:16];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Control registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      firstChan_ff <= ASW_RST_SCAN_SETUP[7:4];
      pairSel_ff   <= ASW_RST_SCAN_SETUP[3:0];
      div_ff       <= ASW_RST_RUN_SETUP[ASW_RUN_DIV_MSB:ASW_RUN_DIV_LSB];
      pinEn_ff     <= ASW_RST_RUN_SETUP[ASW_RUN_PIN_EN];
      timerEn_ff   <= ASW_RST_RUN_SETUP[ASW_RUN_TIMER_EN];
      power_ff     <= ASW_RST_RUN_SETUP[ASW_RUN_POWER];
      repeat_ff    <= ASW_RST_RUN_SETUP[ASW_RUN_REPEAT];
    end else begin
      if (wrScan) begin
        firstChan_ff <= wData_ff[7:4];
        pairSel_ff   <= wData_ff[3:0];
      end
      if (wrRun) begin
        div_ff     <= wData_ff[ASW_RUN_DIV_MSB:ASW_RUN_DIV_LSB];
        pinEn_ff   <= wData_ff[ASW_RUN_PIN_EN];
        timerEn_ff <= wData_ff[ASW_RUN_TIMER_EN];
        power_ff   <= wData_ff[ASW_RUN_POWER];
        repeat_ff  <= wData_ff[ASW_RUN_REPEAT];
      end
    end
  end

  // Triggers. The pin is sampled once; its falling edge is the active one.
  assign trigger = (pinEn_ff & pinPrev_ff & ~triggerInputPin)
                 | (timerEn_ff & timerEvent);

  // A trigger in the same cycle as a software clear still starts a run.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinPrev_ff <= 1'b1;
      runReq_ff  <= ASW_RST_RUN_SETUP[ASW_RUN_REQUEST];
    end else begin
      pinPrev_ff <= triggerInputPin;
      if (trigger) begin
        runReq_ff <= 1'b1;
      end else if (wrRun) begin
        runReq_ff <= wData_ff[ASW_RUN_REQUEST];
      end else if (seqEnd & ~repeat_ff) begin
        runReq_ff <= 1'b0;
      end
    end
  end

  // Prescaler: the ADC clock toggles every code+1 clocks, so one full
  // period lasts 2*code+2 clocks. It stands still while no conversion runs.
  assign periodEnd = (state_ff != S_IDLE) & (divCnt_ff == div_ff)
                   & adcClk_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_ff <= 3'h0;
      adcClk_ff <= 1'b0;
    end else if ((state_ff == S_IDLE) || abort) begin
      divCnt_ff <= 3'h0;
      adcClk_ff <= 1'b0;
    end else if (divCnt_ff == div_ff) begin
      divCnt_ff <= 3'h0;
      adcClk_ff <= ~adcClk_ff;
    end else begin
      divCnt_ff <= divCnt_ff + 3'h1;
    end
  end

  // Sequencer. A control write drops to idle for one clock, and idle loads
  // the first channel again, which restarts the scan from the top.
  assign abort    = ctlWrite | ~power_ff | ~runReq_ff;
  assign startSeq = (state_ff == S_IDLE) & power_ff & runReq_ff
                  & ~ctlWrite;
  assign convEnd  = (state_ff == S_CONVERT) & ~abort & periodEnd
                  & (perCnt_ff == ASW_CONV_PERIODS - 5'h01);
  assign seqEnd   = convEnd & (chan_ff == ASW_LAST_CHANNEL);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff  <= S_IDLE;
      perCnt_ff <= 5'h00;
      chan_ff   <= ASW_RST_SCAN_SETUP[7:4];
    end else begin
      case (state_ff)
        S_IDLE: begin
          perCnt_ff <= 5'h00;
          if (startSeq) begin
            chan_ff  <= firstChan_ff;
            state_ff <= S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          if (abort) begin
            state_ff <= S_IDLE;
          end else if (periodEnd) begin
            perCnt_ff <= perCnt_ff + 5'h01;
            if (perCnt_ff == ASW_SAMPLE_PERIODS - 5'h01) begin
              state_ff <= S_CONVERT;
            end
          end
        end
        S_CONVERT: begin
          if (abort) begin
            state_ff <= S_IDLE;
          end else if (convEnd) begin
            perCnt_ff <= 5'h00;
            if (!seqEnd) begin
              chan_ff  <= chan_ff + 4'h1;
              state_ff <= S_SAMPLE;
            end else if (repeat_ff) begin
              chan_ff  <= firstChan_ff;
              state_ff <= S_SAMPLE;
            end else begin
              state_ff <= S_IDLE;
            end
          end else if (periodEnd) begin
            perCnt_ff <= perCnt_ff + 5'h01;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Window compare on the compared pair.
  assign chanB = pairSel_ff;
  assign chanA = pairSel_ff - 4'h1;

  // Hardware events win over a software clear in the same cycle; a software
  // write of one sets the flag and stands for a software request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seqDone_ff <= 1'b0;
      alarm_ff   <= 1'b0;
      aOver_ff   <= 1'b0;
      bOver_ff   <= 1'b0;
      aUnder_ff  <= 1'b0;
      bUnder_ff  <= 1'b0;
    end else begin
      if (convEnd && chan_ff == chanA) begin
        aOver_ff  <= convResult > upperA_ff;
        aUnder_ff <= convResult < lowerA_ff;
      end
      if (convEnd && chan_ff == chanB) begin
        bOver_ff  <= convResult > upperB_ff;
        bUnder_ff <= convResult < lowerB_ff;
      end
      if (seqEnd) begin
        seqDone_ff <= 1'b1;
      end else if (wrFlags) begin
        seqDone_ff <= wData_ff[ASW_FLG_SEQ_DONE];
      end
      if (convEnd && ((chan_ff == chanA && (convResult > upperA_ff ||
          convResult < lowerA_ff)) || (chan_ff == chanB &&
          (convResult > upperB_ff || convResult < lowerB_ff)))) begin
        alarm_ff <= 1'b1;
      end else if (wrFlags) begin
        alarm_ff <= wData_ff[ASW_FLG_ALARM];
      end
    end
  end

  // Read path.
  assign rdIdx = axiReq.araddr[11:2];

  always_comb begin
    rdByte   = 8'h00;
    rdWord   = 32'h0000_0000;
    rdMapped = 1'b1;
    case (rdIdx)
      ASW_IDX_A_HIGH_UPPER: rdByte = upperA_ff[9:2];
      ASW_IDX_A_HIGH_LOWER: rdByte = {upperA_ff[1:0], 6'h00};
      ASW_IDX_B_HIGH_UPPER: rdByte = upperB_ff[9:2];
      ASW_IDX_B_HIGH_LOWER: rdByte = {upperB_ff[1:0], 6'h00};
      ASW_IDX_SCAN_SETUP:   rdByte = {firstChan_ff, pairSel_ff};
      ASW_IDX_RUN_SETUP:    rdByte = {div_ff, pinEn_ff, timerEn_ff,
                                      power_ff, repeat_ff, runReq_ff};
      ASW_IDX_FLAGS:        rdByte = {seqDone_ff, alarm_ff, bOver_ff,
                                      aOver_ff, bUnder_ff, aUnder_ff, 2'h0};
      ASW_IDX_STATUS:       rdByte = {chan_ff, 3'h0, state_ff[0]};
      ASW_IDX_LOW_LIMITS:   rdWord = {6'h00, lowerB_ff, 6'h00, lowerA_ff};
      default:              rdMapped = 1'b0;
    endcase
    if (rdIdx != ASW_IDX_LOW_LIMITS) begin
      rdWord = {24'h00_0000, rdByte};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arReady_ff <= 1'b0;
      rValid_ff  <= 1'b0;
      rData_ff   <= 32'h0000_0000;
      rResp_ff   <= ASW_RESP_OKAY;
    end else begin
      arReady_ff <= ~nxt_rValid;
      rValid_ff  <= nxt_rValid;
      if (arTake) begin
        rData_ff <= rdWord;
        rResp_ff <= rdMapped ? ASW_RESP_OKAY : ASW_RESP_SLVERR;
      end
    end
  end

  assign axiRsp.awready = awReady_ff;
  assign axiRsp.wready  = wReady_ff;
  assign axiRsp.bvalid  = bValid_ff;
  assign axiRsp.bresp   = bResp_ff;
  assign axiRsp.arready = arReady_ff;
  assign axiRsp.rvalid  = rValid_ff;
  assign axiRsp.rdata   = rData_ff;
  assign axiRsp.rresp   = rResp_ff;

  assign coreCtl.analogEnable = power_ff;
  assign coreCtl.adcClk       = adcClk_ff;
  assign coreCtl.channel      = chan_ff;
  assign coreCtl.busy         = state_ff[0];
  assign coreCtl.holdPhase    = state_ff[1];

endmodule : asw_ctrl

`default_nettype wire

// File: verif/asw_ctrl_sva.sv
// Concurrent checks on the ports of the scan and window control.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module asw_ctrl_sva (
  input wire logic                   clk,             // System clock.
  input wire logic                   rst_n,           // Sync reset.
  input wire asw_pkg::asw_axi_req_t  axiReq,          // Bus requests.
  input wire asw_pkg::asw_axi_rsp_t  axiRsp,          // Bus answers.
  input wire logic                   triggerInputPin, // Pin trigger.
  input wire logic                   timerEvent,      // Timer event.
  input wire logic [9:0]             convResult,      // Core result.
  input wire asw_pkg::asw_core_ctl_t coreCtl          // Core control.
);
  import asw_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pow_off_idle_a: assert property (
    !coreCtl.analogEnable |-> !coreCtl.busy)
    else $error("converter busy while powered down");
  sample_first_a: assert property (
    $rose(coreCtl.busy) |-> !coreCtl.holdPhase [*8])
    else $error("convert phase began before sampling");
  hold_in_busy_a: assert property (
    coreCtl.holdPhase |-> coreCtl.busy)
    else $error("convert phase outside a conversion");
  chan_hold_a: assert property (
    coreCtl.holdPhase |-> $stable(coreCtl.channel))
    else $error("channel moved during a conversion");
  chan_step_a: assert property (
    coreCtl.busy && $past(coreCtl.busy) && $changed(coreCtl.channel)
    && $past(coreCtl.channel) != 4'hf
    |-> coreCtl.channel == $past(coreCtl.channel) + 4'h1)
    else $error("channel did not step by one");
  idle_clk_low_a: assert property (
    !coreCtl.busy && !$past(coreCtl.busy) |-> !coreCtl.adcClk)
    else $error("converter clock running while idle");
  write_resp_a: assert property (
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
    |-> ##[1:2] axiRsp.bvalid)
    else $error("write response late");
  aw_block_a: assert property (
    axiReq.awvalid && axiRsp.awready |=> !axiRsp.awready)
    else $error("address ready stayed high after a take");
  read_answer_a: assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready)
    else $error("read answer late");
endmodule : asw_ctrl_sva

bind asw_ctrl asw_ctrl_sva sva (
  .clk(clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
  .triggerInputPin(triggerInputPin), .timerEvent(timerEvent),
  .convResult(convResult), .coreCtl(coreCtl));
`default_nettype wire

// File: verif/asw_core_model.sv
// Behavioural model of the analog multiplexer and conversion core.
// Assumes the control block takes convResult while busy is high.
`timescale 1ns/10ps
`default_nettype none
module asw_core_model (
  input  wire logic                   clk,        // System clock.
  input  wire asw_pkg::asw_core_ctl_t coreCtl,    // Control from the block.
  output var  logic [9:0]             convResult  // Result of the channel.
);
  import asw_pkg::*;
  logic [9:0] result_ff = 10'h000;
  // The model settles at any converter clock; real parts need software to
  // keep it between 1 MHz and 4 MHz, which this fast clock cannot.
  // A fixed pattern per channel makes window flags predictable; outside a
  // powered conversion the value flips each cycle so a stray take shows.
  always @(posedge clk) begin
    if (coreCtl.busy && coreCtl.analogEnable) begin
      result_ff <= {coreCtl.channel, 6'h2a};
    end else begin
      result_ff <= ~result_ff;
    end
  end
  assign convResult = result_ff;
endmodule : asw_core_model
`default_nettype wire

// File: verif/asw_ctrl_tb.sv
// Self-checking bench of the scan and window control with a core model.
// Assumes the checker is bound to the design through its own file.
`timescale 1ns/10ps
`default_nettype none
module asw_ctrl_tb;
  import asw_pkg::*;
  typedef struct {
    logic        wr;
    logic [9:0]  idx;
    logic [31:0] d;
    logic [31:0] exp;
    logic [1:0]  resp;
  } asw_row_t;
  logic          clk, rst_n, trigPin, timerEv, seen;
  asw_axi_req_t  req;
  asw_axi_rsp_t  rsp;
  asw_core_ctl_t ctl;
  logic [9:0]    res;
  logic [31:0]   rd;
  logic [1:0]    rr;
  logic [3:0]    chQ [$];
  logic          prevBusy = 1'b0;
  logic          prevClk = 1'b0;
  int            err_total, cmp_count, busyCnt, rises;
  asw_row_t rows [12] = '{
    '{1'b0, ASW_IDX_SCAN_SETUP, '0, 32'h0000_000f, ASW_RESP_OKAY},
    '{1'b0, ASW_IDX_RUN_SETUP, '0, 32'h0000_00a0, ASW_RESP_OKAY},
    '{1'b0, ASW_IDX_A_HIGH_UPPER, '0, '0, ASW_RESP_OKAY},
    '{1'b0, ASW_IDX_B_HIGH_LOWER, '0, '0, ASW_RESP_OKAY},
    '{1'b1, ASW_IDX_A_HIGH_UPPER, 32'hffff_ffa5, '0, ASW_RESP_OKAY},
    '{1'b0, ASW_IDX_A_HIGH_UPPER, '0, 32'h0000_00a5, ASW_RESP_OKAY},
    '{1'b1, ASW_IDX_A_HIGH_LOWER, 32'h0000_00ff, '0, ASW_RESP_OKAY},
    '{1'b0, ASW_IDX_A_HIGH_LOWER, '0, 32'h0000_00c0, ASW_RESP_OKAY},
    '{1'b1, ASW_IDX_B_HIGH_LOWER, 32'h0000_007f, '0, ASW_RESP_OKAY},
    '{1'b0, ASW_IDX_B_HIGH_LOWER, '0, 32'h0000_0040, ASW_RESP_OKAY},
    '{1'b1, 10'h010, 32'hffff_ffff, '0, ASW_RESP_SLVERR},
    '{1'b0, 10'h010, '0, '0, ASW_RESP_SLVERR}};
  // Expect flag, pin (1) or timer (0) pulse, run setup value.
  logic [9:0] trg [6] = '{10'h314, 10'h104, 10'h10c, 10'h20c, 10'h004,
                          10'h014};

  asw_ctrl dut (.clk(clk), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp),
    .triggerInputPin(trigPin), .timerEvent(timerEv), .convResult(res),
    .coreCtl(ctl));
  asw_core_model core (.clk(clk), .coreCtl(ctl), .convResult(res));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts busy cycles and converter clock rises, and logs each channel.
  always @(posedge clk) begin
    if (ctl.busy === 1'b1) begin
      busyCnt++;
      if (ctl.adcClk === 1'b1 && !prevClk) rises++;
      if (!prevBusy || ctl.channel !== chQ[$]) chQ.push_back(ctl.channel);
    end
    prevBusy = ctl.busy;
    prevClk = ctl.adcClk;
  end

  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic tmo;
    err_total++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axWr(input logic [9:0] idx, input logic [31:0] d,
                      output logic [1:0] resp);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : axWr

  task automatic axRd(input logic [9:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        d = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : axRd

  task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp);
    axRd(idx, rd, rr);
    chk(rd, exp);
  endtask : rdChk

  // Channel bit 4 set means any channel will do.
  task automatic waitFor(input logic b, input logic [4:0] ch, input int n);
    repeat (n) begin
      @(posedge clk);
      if (ctl.busy === b && (ch[4] || ctl.channel === ch[3:0])) begin
        cmp_count++;
        return;
      end
    end
    tmo();
  endtask : waitFor

  initial begin
    rst_n = 1'b0;
    trigPin = 1'b1;
    timerEv = 1'b0;
    req = '0;
    err_total = 0;
    cmp_count = 0;
    busyCnt = 0;
    rises = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axWr(rows[i].idx, rows[i].d, rr);
      end else begin
        rdChk(rows[i].idx, rows[i].exp);
      end
      chk({30'h0, rr}, {30'h0, rows[i].resp});
    end
    for (int d = 0; d < 8; d++) begin
      axWr(ASW_IDX_SCAN_SETUP, 32'h0000_00f0, rr);
      busyCnt = 0;
      rises = 0;
      chQ.delete();
      axWr(ASW_IDX_RUN_SETUP, {24'h00_0000, d[2:0], 5'h05}, rr);
      waitFor(1'b1, 5'h1f, 20);
      waitFor(1'b0, 5'h1f, 1000);
      repeat (60) @(posedge clk);
      chk(busyCnt, 56 * (d + 1));
      chk(rises, 28);
      chk(chQ.size(), 1);
      chk(chQ[0], 15);
      rdChk(ASW_IDX_RUN_SETUP, {24'h00_0000, d[2:0], 5'h04});
    end
    axWr(ASW_IDX_SCAN_SETUP, 32'h0000_00d0, rr);
    chQ.delete();
    axWr(ASW_IDX_RUN_SETUP, 32'h0000_0005, rr);
    waitFor(1'b1, 5'h1f, 20);
    waitFor(1'b0, 5'h1f, 400);
    chk(chQ.size(), 3);
    foreach (chQ[i]) chk(chQ[i], 13 + i);
    axWr(ASW_IDX_SCAN_SETUP, 32'h0000_00c0, rr);
    axWr(ASW_IDX_RUN_SETUP, 32'h0000_0005, rr);
    waitFor(1'b1, 5'h0d, 200);
    axWr(ASW_IDX_SCAN_SETUP, 32'h0000_00c0, rr);
    waitFor(1'b1, 5'h0c, 20);
    waitFor(1'b0, 5'h1f, 400);
    axWr(ASW_IDX_SCAN_SETUP, 32'h0000_00f0, rr);
    rises = 0;
    axWr(ASW_IDX_RUN_SETUP, 32'h0000_0007, rr);
    repeat (400) @(posedge clk);
    chk(rises > 84, 1);
    axWr(ASW_IDX_RUN_SETUP, 32'h0000_0004, rr);
    waitFor(1'b0, 5'h1f, 4);
    rdChk(ASW_IDX_RUN_SETUP, 32'h0000_0004);
    foreach (trg[i]) begin
      axWr(ASW_IDX_RUN_SETUP, {24'h00_0000, trg[i][7:0]}, rr);
      @(posedge clk);
      if (trg[i][8]) trigPin <= 1'b0;
      else timerEv <= 1'b1;
      @(posedge clk);
      timerEv <= 1'b0;
      @(posedge clk);
      trigPin <= 1'b1;
      seen = 1'b0;
      repeat (8) begin
        @(posedge clk);
        if (ctl.busy === 1'b1) seen = 1'b1;
      end
      chk(seen, trg[i][9]);
      if (seen) begin
        rdChk(ASW_IDX_RUN_SETUP,
              {24'h00_0000, trg[i][7:0] | 8'h01});
      end
      waitFor(1'b0, 5'h1f, 200);
      rdChk(ASW_IDX_RUN_SETUP, {24'h00_0000, trg[i][7:0]});
    end
    // Limit A is 0x3e9 and B is 0x02a, one below and equal to the results.
    // Lower limit B is 0x02b, one above the channel 0 result.
    axWr(ASW_IDX_LOW_LIMITS, 32'h002b_0000, rr);
    axWr(ASW_IDX_A_HIGH_UPPER, 32'h0000_00fa, rr);
    axWr(ASW_IDX_A_HIGH_LOWER, 32'h0000_0040, rr);
    axWr(ASW_IDX_B_HIGH_UPPER, 32'h0000_000a, rr);
    axWr(ASW_IDX_B_HIGH_LOWER, 32'h0000_0080, rr);
    axWr(ASW_IDX_FLAGS, '0, rr);
    axWr(ASW_IDX_SCAN_SETUP, '0, rr);
    axWr(ASW_IDX_RUN_SETUP, 32'h0000_0005, rr);
    waitFor(1'b1, 5'h1f, 20);
    waitFor(1'b0, 5'h1f, 1200);
    rdChk(ASW_IDX_FLAGS, 32'h0000_00d8);
    // Reset in mid-run: the converter must be idle and powered down after.
    axWr(ASW_IDX_RUN_SETUP, 32'h0000_0007, rr);
    waitFor(1'b1, 5'h1f, 20);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(ASW_IDX_RUN_SETUP, 32'h0000_00a0);
    chk(ctl.busy, 1'b0);
    // A run request without power must not start a conversion.
    axWr(ASW_IDX_RUN_SETUP, 32'h0000_0001, rr);
    repeat (8) @(posedge clk);
    chk(ctl.busy, 1'b0);
    stop_test();
  end
endmodule : asw_ctrl_tb
`default_nettype wire
